/* serial_bus_pkg.sv */
// Purpose: constants and types of the serial bus unit
// Assumes: 32-bit AHB-Lite register access, 50 MHz base clock
// Notes: one register per aligned word
package serial_bus_pkg;
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_TXBUF = 8'h08;
    localparam logic [7:0] OFS_RXBUF = 8'h0c;
    localparam logic [7:0] OFS_BUSCTL = 8'h10;
    localparam logic [7:0] OFS_ADDR = 8'h14;
    localparam logic [7:0] OFS_TXSTAT = 8'h18;
    localparam logic [7:0] OFS_RXSTAT = 8'h1c;
    localparam logic [7:0] OFS_CMP = 8'h20;
    localparam logic [7:0] OFS_IRQ = 8'h24;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int TXBUF_LEN_LSB = 8;
    localparam int RXBUF_OVR_BIT = 8;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [11:0] ADDR_RESET = 12'h000;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLOCK_HZ = 50_000_000;
    localparam int EXT_MIN_PERIOD_CYC = 20;
    localparam int INT_MIN_DIV_BOTH = 6;
    localparam int INT_MIN_DIV_OTHER = 20;
    localparam logic [15:0] HALF_EXTRA = 16'h0002;
    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic tx_irq_timing_sel;
        logic bit_order_sel;
        logic clock_source_sel;
        logic pad;
        logic [1:0] serial_mode_sel;
    } mode_t;
    typedef struct packed {
        logic output_polarity_sel;
        logic input_polarity_sel;
        logic rx_enable;
        logic tx_enable;
    } ctrl_t;
    typedef struct packed {
        logic [1:0] bus_mode_sel;
        logic noise_filter_enable;
        logic busy_flag_sel;
        logic frame_start_bit;
        logic bus_unit_enable;
    } busctl_t;
    typedef struct packed {
        logic arbitration_lost_flag;
        logic tx_timing_error_flag;
        logic tx_max_byte_error_flag;
        logic ack_error_flag;
        logic tx_normal_done_flag;
    } txstat_t;
    typedef struct packed {
        logic rx_other_cause_flag;
        logic rx_timing_error_flag;
        logic rx_max_byte_error_flag;
        logic parity_error_flag;
        logic rx_normal_done_flag;
    } rxstat_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } state_t;
endpackage

/* auto_serial_bus_unit.sv */
// Purpose: serial bus mode of the waveform-backed serial unit
// Assumes: AHB-Lite slave, single word transfers, zero wait
// Notes: transfer clock internal (divider) or from the clock pin
//
// Operation
// [RULE_01] Software enables transmit, then writes buffer
// [RULE_02] Receive needs both enables and a write
// [RULE_03] Timing select 0: request on shifter load
// [RULE_04] Timing select 1: request on shift end
// [RULE_05] Receive request when word reaches buffer
// [RULE_06] Overrun if next word lands unread
// [RULE_07] Buffer content undefined after overrun
// [RULE_08] Selectable first bit: bit 0 or 7
// [RULE_09] Polarity controls invert output and input pins
// [RULE_10] Word length 1 to 8, written with data
// [RULE_11] Internal clock divide six or twenty minimum
// [RULE_12] External clock period twenty cycles minimum
// [RULE_13] Software sets base timer controls for mode
// [RULE_14] Software sets waveform channels for communication
// [RULE_15] Software enables used waveform channels first
// [RULE_16] Mode register holds mode, clock, order, timing
// [RULE_17] Control register reports buffer, shifter, receive flags
// [RULE_18] Bus control bits and 12-bit own address
// [RULE_19] Transmit status: done, ack, max, timing, arbitration
// [RULE_20] Receive status: done, parity, max, timing, other
// [RULE_21] Receive buffer holds data and overrun flag
// [RULE_22] Internal bit rate is base over 2(n+2)
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module auto_serial_bus_unit
    import serial_bus_pkg::*;
#(
    parameter int MAX_FRAME_WORDS = 32
)(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_serial_in_pin,
    output logic o_serial_out_pin,
    input wire logic i_serial_clock_pin,
    output logic o_serial_clock_pin,
    output logic o_serial_clock_oe_b,
    output logic o_tx_irq_request,
    output logic o_rx_irq_request
);
    if (MAX_FRAME_WORDS < 1 || MAX_FRAME_WORDS > 255)
        $error("MAX_FRAME_WORDS out of range");
    // ****************************************
    // Bus slave
    // ****************************************
    logic wr_q;
    logic [7:0] wa_q;
    mode_t mode_q;
    ctrl_t ctrl_q;
    busctl_t bus_q;
    txstat_t txs_q;
    rxstat_t rxs_q;
    logic [11:0] addr_q;
    logic [15:0] cmp_q;
    logic [7:0] tb_data_q;
    logic [2:0] tb_len_q;
    logic tb_full_q;
    logic [7:0] rb_q;
    logic ovr_q;
    logic rx_done_q;
    logic [1:0] irq_q;
    state_t st_q;
    wire take = i_hsel && i_hready && i_htrans[1];
    wire [7:0] ra = i_haddr[7:0];
    wire rd_take = take && !i_hwrite;
    wire rd_rb = rd_take && ra == OFS_RXBUF;
    wire w_mode = wr_q && wa_q == OFS_MODE;
    wire w_ctrl = wr_q && wa_q == OFS_CTRL;
    wire w_tb = wr_q && wa_q == OFS_TXBUF;
    wire w_bus = wr_q && wa_q == OFS_BUSCTL;
    wire w_addr = wr_q && wa_q == OFS_ADDR;
    wire w_txs = wr_q && wa_q == OFS_TXSTAT;
    wire w_rxs = wr_q && wa_q == OFS_RXSTAT;
    wire w_cmp = wr_q && wa_q == OFS_CMP;
    wire w_irq = wr_q && wa_q == OFS_IRQ;
    wire shifter_empty = st_q == ST_IDLE;
    wire [31:0] rd_mux =
        ra == OFS_MODE ? {26'h0, mode_q} :
        ra == OFS_CTRL ? {25'h0, ctrl_q, rx_done_q, shifter_empty, !tb_full_q} : // [RULE_17]
        ra == OFS_TXBUF ? {21'h0, tb_len_q, tb_data_q} :
        ra == OFS_RXBUF ? {23'h0, ovr_q, rb_q} : // [RULE_21]
        ra == OFS_BUSCTL ? {25'h0, !shifter_empty, bus_q} :
        ra == OFS_ADDR ? {20'h0, addr_q} :
        ra == OFS_TXSTAT ? {27'h0, txs_q} : // [RULE_19]
        ra == OFS_RXSTAT ? {27'h0, rxs_q} : // [RULE_20]
        ra == OFS_CMP ? {16'h0, cmp_q} :
        ra == OFS_IRQ ? {30'h0, irq_q} : 32'h0;
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            o_hrdata <= 32'h0;
            o_hreadyout <= 1'b0;
            o_hresp <= 1'b0;
        end
        else
        begin
            wr_q <= take && i_hwrite;
            wa_q <= ra;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            if (rd_take)
                o_hrdata <= rd_mux;
        end
    end
    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            mode_q <= '0;
            ctrl_q <= '0;
            addr_q <= ADDR_RESET;
            cmp_q <= CMP_RESET;
        end
        else
        begin
            if (w_mode)
                mode_q <= mode_t'(i_hwdata[5:0]); // [RULE_16]
            if (w_ctrl)
                ctrl_q <= ctrl_t'(i_hwdata[6:3]);
            if (w_addr)
                addr_q <= i_hwdata[11:0]; // [RULE_18]
            if (w_cmp)
                cmp_q <= i_hwdata[15:0];
        end
    end
    // ****************************************
    // Pin synchronisers and filter
    // ****************************************
    logic [1:0] rx_s_q;
    logic [1:0] ck_s_q;
    logic [1:0] rx_h_q;
    logic ck_old_q;
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_s_q <= 2'b11;
            ck_s_q <= 2'b11;
            rx_h_q <= 2'b11;
            ck_old_q <= 1'b1;
        end
        else
        begin
            rx_s_q <= {rx_s_q[0], i_serial_in_pin};
            ck_s_q <= {ck_s_q[0], i_serial_clock_pin};
            rx_h_q <= {rx_h_q[0], rx_s_q[1]};
            ck_old_q <= ck_s_q[1];
        end
    end
    wire rx_maj = (rx_s_q[1] & rx_h_q[0]) | (rx_s_q[1] & rx_h_q[1]) | (rx_h_q[0] & rx_h_q[1]);
    wire rx_raw = bus_q.noise_filter_enable ? rx_maj : rx_s_q[1];
    wire rx_bit = rx_raw ^ ctrl_q.input_polarity_sel; // [RULE_09]
    // ****************************************
    // Transfer clock
    // ****************************************
    logic [16:0] half_q;
    logic ph_q;
    logic [7:0] per_q;
    wire ext = mode_q.clock_source_sel;
    wire running = st_q == ST_SHIFT;
    wire half_end = half_q == 17'(cmp_q) + 17'(HALF_EXTRA) - 17'h00001; // [RULE_22]
    wire int_tick = !ext && running && half_end;
    wire samp_en = ext ? (running && ck_s_q[1] && !ck_old_q) : (int_tick && !ph_q);
    wire shift_en = ext ? (running && !ck_s_q[1] && ck_old_q && ph_q) : (int_tick && ph_q);
    wire too_fast = ext && samp_en && per_q < 8'(EXT_MIN_PERIOD_CYC); // [RULE_12]
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            half_q <= 17'h00000;
            ph_q <= 1'b0;
            per_q <= 8'h0;
        end
        else
        begin
            half_q <= (!running || half_end) ? 17'h00000 : half_q + 17'h00001;
            if (!running)
                ph_q <= 1'b0;
            else if (samp_en || shift_en)
                ph_q <= !ph_q;
            if (samp_en)
                per_q <= 8'h01;
            else if (per_q != 8'hff)
                per_q <= per_q + 8'h01;
        end
    end
    // ****************************************
    // Transmit buffer and shifter
    // ****************************************
    logic [7:0] sh_q;
    logic [2:0] len_q;
    logic [2:0] cnt_q;
    logic [7:0] rx_sh_q;
    logic rx_on_q;
    logic [7:0] words_q;
    logic mism_hi;
    logic mism_lo;
    wire on = mode_q.serial_mode_sel != 2'b00;
    wire load = on && ctrl_q.tx_enable && tb_full_q && st_q == ST_IDLE; // [RULE_01]
    wire [2:0] pos = mode_q.bit_order_sel ? 3'd7 - cnt_q : cnt_q; // [RULE_08]
    wire tx_bit = sh_q[pos];
    wire last = cnt_q == len_q;
    wire word_end = shift_en && last;
    wire rx_store = word_end && rx_on_q; // [RULE_05]
    wire frame = bus_q.bus_unit_enable && bus_q.frame_start_bit;
    wire max_hit = frame && word_end && words_q >= 8'(MAX_FRAME_WORDS - 1);
    wire frame_end = frame && word_end && (!tb_full_q || max_hit);
    wire [7:0] rx_word = rx_sh_q | (8'h01 << pos) & {8{rx_bit}};
    wire [7:0] rx_next = samp_en ? (rx_word & ~({7'h0, !rx_bit} << pos)) : rx_sh_q;
    wire par_bad = bus_q.bus_mode_sel[0] && ^rx_sh_q;
    assign mism_hi = samp_en && tx_bit && !rx_bit;
    assign mism_lo = samp_en && !tx_bit && rx_bit;
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_q <= ST_IDLE;
            tb_full_q <= 1'b0;
            tb_data_q <= 8'h00;
            tb_len_q <= 3'h0;
            sh_q <= 8'h00;
            len_q <= 3'h0;
            cnt_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_on_q <= 1'b0;
        end
        else
        begin
            if (w_tb)
            begin
                tb_data_q <= i_hwdata[7:0];
                tb_len_q <= i_hwdata[TXBUF_LEN_LSB+:3]; // [RULE_10]
                tb_full_q <= 1'b1;
            end
            else if (load)
                tb_full_q <= 1'b0;
            rx_sh_q <= rx_next;
            unique case (st_q)
                ST_IDLE:
                begin
                    if (load)
                    begin
                        st_q <= ST_SHIFT;
                        sh_q <= tb_data_q;
                        len_q <= tb_len_q;
                        cnt_q <= 3'h0;
                        rx_sh_q <= 8'h00;
                        rx_on_q <= ctrl_q.rx_enable; // [RULE_02]
                    end
                end
                ST_SHIFT:
                begin
                    if (shift_en)
                        cnt_q <= cnt_q + 3'h1;
                    if (word_end)
                        st_q <= ST_IDLE;
                end
            endcase
        end
    end
    // ****************************************
    // Receive buffer, flags, requests
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rb_q <= 8'h00;
            ovr_q <= 1'b0;
            rx_done_q <= 1'b0;
            irq_q <= 2'b00;
        end
        else
        begin
            if (rx_store)
                rb_q <= rx_sh_q; // [RULE_07]
            if (rx_store && rx_done_q)
                ovr_q <= 1'b1; // [RULE_06]
            else if (rd_rb)
                ovr_q <= 1'b0;
            if (rx_store)
                rx_done_q <= 1'b1;
            else if (rd_rb)
                rx_done_q <= 1'b0;
            irq_q[0] <= (load && !mode_q.tx_irq_timing_sel) // [RULE_03]
                || (word_end && mode_q.tx_irq_timing_sel) // [RULE_04]
                || (irq_q[0] && !(w_irq && i_hwdata[0]));
            irq_q[1] <= rx_store || (irq_q[1] && !(w_irq && i_hwdata[1]));
        end
    end
    // ****************************************
    // Frame control and status
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            bus_q <= '0;
            txs_q <= '0;
            rxs_q <= '0;
            words_q <= 8'h00;
        end
        else
        begin
            if (w_bus)
                bus_q <= busctl_t'(i_hwdata[5:0]); // [RULE_18]
            else if (frame_end)
                bus_q.frame_start_bit <= 1'b0;
            if (!frame)
                words_q <= 8'h00;
            else if (word_end)
                words_q <= words_q + 8'h01;
            txs_q <= (w_txs ? txs_q & ~txstat_t'(i_hwdata[4:0]) : txs_q) | { // [RULE_19]
                frame && mism_hi,
                frame && too_fast,
                max_hit,
                frame && mism_lo && bus_q.bus_mode_sel[1],
                frame_end && !max_hit};
            rxs_q <= (w_rxs ? rxs_q & ~rxstat_t'(i_hwdata[4:0]) : rxs_q) | { // [RULE_20]
                rx_store && !frame,
                rx_on_q && too_fast,
                max_hit && rx_on_q,
                rx_store && par_bad,
                rx_store && frame && !par_bad};
        end
    end
    // ****************************************
    // Pin drivers
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_serial_out_pin <= 1'b1;
            o_serial_clock_pin <= 1'b1;
            o_serial_clock_oe_b <= 1'b1;
            o_tx_irq_request <= 1'b0;
            o_rx_irq_request <= 1'b0;
        end
        else
        begin
            o_serial_out_pin <= (running ? tx_bit : 1'b1) ^ ctrl_q.output_polarity_sel; // [RULE_09]
            o_serial_clock_pin <= ext || !running || ph_q;
            o_serial_clock_oe_b <= !(on && !ext);
            o_tx_irq_request <= irq_q[0];
            o_rx_irq_request <= irq_q[1];
        end
    end
endmodule // auto_serial_bus_unit

/* serial_bus_checker_sva.sv */
// Purpose: port checker of the serial bus unit
// Assumes: one clock domain, reset active low
// Notes: attached to the top module by bind
`timescale 1ns/10ps
module serial_bus_checker
    import serial_bus_pkg::*;
#(
    parameter int MAX_FRAME_WORDS = 32
)(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic o_serial_clock_pin,
    input wire logic o_serial_clock_oe_b,
    input wire logic o_tx_irq_request,
    input wire logic o_rx_irq_request
);
    // ****************************************
    // Helpers
    // ****************************************
    wire logic taken = i_hsel & i_hready & i_htrans[1];
    wire logic irq_wr = taken & i_hwrite & (i_haddr[7:0] == OFS_IRQ);
    logic [2:0] age_q;
    logic [2:0] age_d;
    assign age_d = irq_wr ? 3'h0 : ((age_q == 3'h7) ? age_q : age_q + 3'h1);
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            age_q <= 3'h7;
        else
            age_q <= age_d;
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    sequence rd_at(logic [7:0] ofs);
        taken && !i_hwrite && i_haddr[7:0] == ofs;
    endsequence
    sequence rd_unmapped;
        taken && !i_hwrite && i_haddr[7:0] >= 8'h28;
    endsequence
    // ****************************************
    // Assertions
    // ****************************************
    AST_HRESP_OKAY:
        assert property (o_hresp == 1'b0)
        else $error("response not okay");
    AST_READY_AFTER_RESET:
        assert property ($past(i_rst_b) |-> o_hreadyout)
        else $error("ready low after reset");
    AST_RDATA_STANDS:
        assert property ($changed(o_hrdata) |-> $past(taken && !i_hwrite))
        else $error("read data changed without read");
    AST_UNMAPPED_ZERO:
        assert property (rd_unmapped |=> o_hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RXBUF_UPPER_ZERO:
        assert property (rd_at(OFS_RXBUF) |=> o_hrdata[31:9] == 23'h0)
        else $error("receive buffer upper bits set");
    AST_CLK_LOW_MIN:
        assert property ($fell(o_serial_clock_pin) |=> !o_serial_clock_pin)
        else $error("clock low half too short");
    AST_CLK_HIGH_MIN:
        assert property ($rose(o_serial_clock_pin) |=> o_serial_clock_pin)
        else $error("clock high half too short");
    AST_CLK_ONLY_DRIVEN:
        assert property ($changed(o_serial_clock_pin) |->
            (!o_serial_clock_oe_b || !$past(o_serial_clock_oe_b)))
        else $error("clock pin moved while not driven");
    AST_IRQ_CLEAR_CAUSE:
        assert property (($fell(o_tx_irq_request) || $fell(o_rx_irq_request))
            |-> age_q <= 3'h4)
        else $error("request dropped without clear");
endmodule // serial_bus_checker

bind auto_serial_bus_unit serial_bus_checker #(.MAX_FRAME_WORDS(MAX_FRAME_WORDS)) u_chk (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_serial_clock_pin(o_serial_clock_pin),
    .o_serial_clock_oe_b(o_serial_clock_oe_b), .o_tx_irq_request(o_tx_irq_request),
    .o_rx_irq_request(o_rx_irq_request)
);

/* serial_bus_node.sv */
// Purpose: far-side node on the serial bus
// Assumes: wired-AND line shared with the unit
// Notes: external clock idles high outside frames
`timescale 1ns/10ps
module serial_bus_node #(
    parameter int HALF_CYC = 10
)(
    input wire logic i_clock,
    input wire logic i_line_drive,
    input wire logic i_pull_low,
    input wire logic i_clk_run,
    output logic o_line,
    output logic o_ext_clock
);
    // ****************************************
    // Line and clock
    // ****************************************
    int cnt_q = 0;
    assign o_line = i_line_drive & ~i_pull_low;
    initial o_ext_clock = 1'b1;
    always @(posedge i_clock)
    begin
        if (i_clk_run || !o_ext_clock)
        begin
            cnt_q <= (cnt_q == HALF_CYC - 1) ? 0 : cnt_q + 1;
            if (cnt_q == HALF_CYC - 1) // Period of 2*HALF_CYC base cycles
                o_ext_clock <= ~o_ext_clock;
        end
    end
endmodule // serial_bus_node

/* tb_top.sv */
// Purpose: register-level tests of the serial bus unit
// Assumes: transmit line looped back through the far node
// Notes: transfer clock divider n = 3, ten cycles a bit
`timescale 1ns/10ps
module tb_top
    import serial_bus_pkg::*;
;
    logic i_clock, i_rst_b, hsel, hwrite, pull_low, ext_run, clk_pin_q;
    logic hreadyout, hresp, line, ext_clk, out_pin, clk_pin, clk_oe_b, tx_irq, rx_irq;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, x;
    logic bits_q[$];
    int miscompares = 0;
    int total_checks = 0;
    int len, n;
    logic [7:0] cmode [4] = '{8'h01, 8'h31, 8'h21, 8'h11};
    logic [7:0] cctrl [4] = '{8'h38, 8'h78, 8'h58, 8'h18};
    logic [10:0] ctx [4] = '{11'h7a5, 11'h73c, 11'h206, 11'h080};
    auto_serial_bus_unit dut (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .i_serial_in_pin(line), .o_serial_out_pin(out_pin), .i_serial_clock_pin(ext_clk),
        .o_serial_clock_pin(clk_pin), .o_serial_clock_oe_b(clk_oe_b),
        .o_tx_irq_request(tx_irq), .o_rx_irq_request(rx_irq)
    );
    serial_bus_node #(.HALF_CYC(10)) node (
        .i_clock(i_clock), .i_line_drive(out_pin), .i_pull_low(pull_low),
        .i_clk_run(ext_run), .o_line(line), .o_ext_clock(ext_clk)
    );
    // ****************************************
    // Clock, monitor, tasks
    // ****************************************
    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    always @(posedge i_clock)
    begin
        clk_pin_q <= clk_pin;
        if (clk_pin === 1'b1 && clk_pin_q === 1'b0)
            bits_q.push_back(out_pin);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge i_clock);
        while (hreadyout !== 1'b1) @(posedge i_clock);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge i_clock);
        while (hreadyout !== 1'b1) @(posedge i_clock);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] y;
        ahb(1'b1, a, d, y);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] y;
        ahb(1'b0, a, 32'h0, y);
        check(y, e);
    endtask
    task automatic wait_rx();
        n = 0;
        while (rx_irq !== 1'b1 && n < 3000)
        begin
            @(posedge i_clock);
            n++;
        end
        check(rx_irq, 1'b1);
    endtask
    task automatic end_test(input string name);
        $display("test %s finished", name);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge i_clock);
        miscompares++;
        report_and_stop();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        i_rst_b = 1'b0;
        {hsel, hwrite, pull_low, ext_run, htrans, haddr, hwdata} = '0;
        repeat (2) @(posedge i_clock);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_clock);
        rd_chk(OFS_CTRL, 32'h3);
        rd_chk(OFS_CMP, {16'h0, CMP_RESET});
        rd_chk(OFS_ADDR, {20'h0, ADDR_RESET});
        wr(OFS_ADDR, 32'h1abc);
        rd_chk(OFS_ADDR, 32'habc);
        wr(OFS_MODE, 32'h3b);
        rd_chk(OFS_MODE, 32'h3b);
        wr(OFS_BUSCTL, 32'h3d);
        rd_chk(OFS_BUSCTL, 32'h3d);
        wr(OFS_BUSCTL, 32'h0);
        wr(8'h2c, 32'hffff_ffff);
        rd_chk(8'h2c, 32'h0);
        end_test("registers");
        wr(OFS_CMP, 32'h3);
        for (int k = 0; k < 4; k++)
        begin
            wr(OFS_MODE, {24'h0, cmode[k]});
            wr(OFS_CTRL, {24'h0, cctrl[k]});
            bits_q.delete();
            wr(OFS_TXBUF, {21'h0, ctx[k]});
            repeat (4) @(posedge i_clock);
            check(tx_irq, !cmode[k][5]);
            wait_rx();
            repeat (2) @(posedge i_clock);
            check(tx_irq, 1'b1);
            check(clk_oe_b, 1'b0);
            len = ctx[k][10:8] + 1;
            check(bits_q.size(), len);
            for (int i = 0; i < len; i++)
                check(bits_q[i], ctx[k][cmode[k][4] ? 7 - i : i] ^ cctrl[k][6]);
            ahb(1'b0, OFS_RXBUF, 32'h0, x);
            if (len == 8)
                check(x, {24'h0, ctx[k][7:0] ^ {8{cctrl[k][6] ^ cctrl[k][5]}}});
            wr(OFS_IRQ, 32'h3);
            rd_chk(OFS_IRQ, 32'h0);
        end
        end_test("transfers");
        wr(OFS_MODE, 32'h01);
        wr(OFS_CTRL, 32'h18);
        wr(OFS_TXBUF, 32'h755);
        wait_rx();
        wr(OFS_IRQ, 32'h3);
        wr(OFS_TXBUF, 32'h7aa);
        wait_rx();
        rd_chk(OFS_CTRL, 32'h1f);
        ahb(1'b0, OFS_RXBUF, 32'h0, x);
        check(x[RXBUF_OVR_BIT], 1'b1);
        ahb(1'b0, OFS_RXBUF, 32'h0, x); // Data bits left unchecked
        check(x[RXBUF_OVR_BIT], 1'b0);
        end_test("overrun");
        wr(OFS_IRQ, 32'h3);
        wr(OFS_MODE, 32'h09);
        wr(OFS_TXBUF, 32'h7c3);
        ext_run <= 1'b1;
        check(clk_oe_b, 1'b1);
        wait_rx();
        ext_run <= 1'b0;
        rd_chk(OFS_RXBUF, 32'hc3);
        end_test("external clock");
        wr(OFS_IRQ, 32'h3);
        wr(OFS_MODE, 32'h01);
        wr(OFS_BUSCTL, 32'h11);
        wr(OFS_TXBUF, 32'h707);
        wait_rx();
        ahb(1'b0, OFS_RXSTAT, 32'h0, x);
        check(x[1], 1'b1);
        check(x[4], 1'b1);
        wr(OFS_RXSTAT, 32'h1f);
        rd_chk(OFS_RXSTAT, 32'h0);
        ahb(1'b0, OFS_RXBUF, 32'h0, x);
        end_test("receive status");
        wr(OFS_IRQ, 32'h3);
        wr(OFS_BUSCTL, 32'h03);
        pull_low <= 1'b1;
        wr(OFS_TXBUF, 32'h7ff);
        n = 0;
        do
        begin
            ahb(1'b0, OFS_TXSTAT, 32'h0, x);
            n++;
        end
        while (x[4] !== 1'b1 && n < 100);
        check(x[4], 1'b1);
        pull_low <= 1'b0;
        end_test("arbitration");
        report_and_stop();
    end
endmodule // tb_top
